// [pcg_defines.svh]
// constants of the clock controller: reset values, encodings, timing counts
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

// relock down-counter load, counted in main oscillator ticks
`define PCG_RELOCK_LOAD 13'h1200
`define PCG_RELOCK_W 13

// oscillator source field encodings
`define PCG_OSC_MAIN 2'h0
`define PCG_OSC_INT 2'h1
`define PCG_OSC_INT4 2'h2

// checker indices and timing
`define PCG_CHK_PLL 0
`define PCG_CHK_INT 1
`define PCG_CHK_MAIN 2
`define PCG_CHK_DIV_LAST 6'h3f
`define PCG_CHK_CNT_W 8
`define PCG_CHK_MIN_FAST 8'h01

// crystal translation: plain defaults, no part-specific table
`define PCG_CRYSTAL_SELECT_RESET 4'h0
`define PCG_CRYSTAL_SELECT_BASE_KHZ 32'h0000_0fa0
`define PCG_CRYSTAL_SELECT_STEP_KHZ 32'h0000_0100
`define PCG_VCO_KHZ 32'h0006_1a80
`define PCG_REF_DIV 32'h0000_0002
`define PCG_REF_FIELD 4'h1

// gating register reset values
`define PCG_GATE0_RESET 32'h0000_0040

`endif

// [pcg_pkg.sv]
// types shared by the clock controller modules
package pcg_pkg;

  typedef enum logic [1:0] {
    PCG_RUN = 2'b00,
    PCG_SLEEP = 2'b01,
    PCG_DEEP = 2'b10,
    PCG_RESTORE = 2'b11
  } pcg_mode_type;

  typedef enum logic [1:0] {
    PCG_SRC_MAIN = 2'b00,
    PCG_SRC_INT = 2'b01,
    PCG_SRC_INT4 = 2'b10,
    PCG_SRC_PLL = 2'b11
  } pcg_src_type;

  typedef struct packed {
    logic [3:0] crystalSelect;
    logic [1:0] oscSourceSelect;
    logic bypass;
    logic useDivider;
    logic [3:0] systemDivider;
    logic pllPowerDown;
    logic pllOutputDisable;
    logic pllCheckEnable;
    logic intOscCheckEnable;
    logic mainOscCheckEnable;
    logic autoGating;
    logic lockIntMask;
    logic deepSleepIntOsc;
  } pcg_cfg_type;

  typedef struct packed {
    logic runWr;
    logic sleepWr;
    logic deepWr;
    logic [31:0] data;
  } pcg_gate_wr_type;

endpackage : pcg_pkg

// [pcg_clock_checker.sv]
// one clock verification circuit: fast clock checked against slow ticks
`timescale 1ns/1ps
`include "pcg_defines.svh"

module pcg_clock_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic fastTick,
  input wire logic slowTick,
  input wire logic clear,
  output logic fail
);
  import pcg_pkg::*;

  logic [`PCG_CHK_CNT_W-1:0] count;
  logic [`PCG_CHK_CNT_W-1:0] next_count;
  logic next_fail;
  logic armed;
  logic next_armed;

  always_comb
  begin
    next_count = count;
    next_fail = fail;
    next_armed = armed;
    if (clear)
      next_fail = 1'b0;
    if (!enable)
    begin
      next_count = '0;
      next_armed = 1'b0;
    end
    else if (slowTick)
    begin
      next_count = '0;
      // first slow tick after enable only opens a full window
      next_armed = 1'b1;
      // set wins over a clear in the same cycle
      if (armed && count < `PCG_CHK_MIN_FAST)
        next_fail = 1'b1;
    end
    else if (fastTick && count != '1)
      next_count = count + 1'b1;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count <= '0;
      fail <= 1'b0;
      armed <= 1'b0;
    end
    else
    begin
      count <= next_count;
      fail <= next_fail;
      armed <= next_armed;
    end
  end

  property p_detect;
    @(posedge sys_clk) disable iff (sys_rst)
    enable && armed && slowTick && count == '0 |=> fail;
  endproperty
  a_detect: assert property (p_detect)
    else $error("missing fast clock not flagged");

  property p_persist;
    @(posedge sys_clk) disable iff (sys_rst)
    fail && !clear |=> fail;
  endproperty
  a_persist: assert property (p_persist)
    else $error("failure indication dropped without clear");

endmodule : pcg_clock_checker

// [pcg_clock_control.sv]
// clock controller: pll control, relock timer, checkers, sleep gating
// Operation
// - PLL stays powered down after reset until software configures it.
// - Crystal selection change retranslates PLL settings into readable register.
// - Translation gives a VCO frequency within 1% of target.
// - Normal mode drives PLL output; power-down disables and blanks it.
// - Relock only on crystal change or PLL power-up, not same value.
// - Relock down-counter on main oscillator, loaded with 0x1200.
// - PLL selected in one step: stay on oscillator until relock ends.
// - Raw lock flag set on relock done; maskable lock interrupt.
// - Three checkers: main checks PLL, main checks int, int/64 checks main.
// - Checker failure switches to a working clock and interrupts.
// - Failure and forced switch persist until verify clear or reset.
// - Each checker has its own enable bit.
// - Per-peripheral run/sleep/deep gating; capability mask limits writes.
// - Sleep stops core and memory; peripherals use sleep or run set.
// - Deep-sleep stops core and memory; peripherals use deep or run set.
// - Deep-sleep clock: main oscillator or chosen internal oscillator.
// - Entering deep-sleep powers the PLL down.
// - Deep-sleep exit restores saved clock before re-enabling clocks.
// - Clearing power-down powers PLL; clearing output-disable enables output.
// - Source 0 main, 1 internal, 2 internal/4, via PLL or bypass.
// - System divider divides by field value plus one.
`timescale 1ns/1ps
`include "pcg_defines.svh"

module pcg_clock_control (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire pcg_pkg::pcg_cfg_type cfg,
  input wire pcg_pkg::pcg_gate_wr_type gateWr,
  input wire logic [31:0] capabilityMask,
  input wire logic verifyClear,
  input wire logic lockFlagClear,
  input wire logic sleepReq,
  input wire logic deepSleepEnable,
  input wire logic wakeEvent,
  input wire logic mainOscIn,
  input wire logic intOscIn,
  input wire logic pllTapIn,
  output logic [15:0] pllTranslation,
  output logic pllPowerDown,
  output logic pllOutputDisable,
  output pcg_pkg::pcg_src_type clkSel,
  output logic [4:0] clkDivisor,
  output logic pllLockRawFlag,
  output logic lockIrq,
  output logic [2:0] verifyFail,
  output logic verifyIrq,
  output logic coreClkEnable,
  output logic [31:0] periphClkEnable,
  output logic [31:0] runGating,
  output logic [31:0] sleepGating,
  output logic [31:0] deepGating,
  output logic mainOscPowerDown
);
  import pcg_pkg::*;

  // oscillator inputs: two-flop sync plus an edge stage
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [2:0] syncC;
  logic [2:0] ticks;
  logic mainTick;
  logic intTick;
  logic pllTick;
  logic [5:0] intDiv;
  logic [5:0] next_intDiv;
  logic intDiv64Tick;
  logic next_intDiv64Tick;

  assign ticks = syncB & ~syncC;
  assign pllTick = ticks[0];
  assign intTick = ticks[1];
  assign mainTick = ticks[2];

  always_comb
  begin
    next_intDiv = intTick ? intDiv + 1'b1 : intDiv;
    next_intDiv64Tick = intTick && intDiv == `PCG_CHK_DIV_LAST;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
      intDiv <= '0;
      intDiv64Tick <= 1'b0;
    end
    else
    begin
      syncA <= {mainOscIn, intOscIn, pllTapIn};
      syncB <= syncA;
      syncC <= syncB;
      intDiv <= next_intDiv;
      intDiv64Tick <= next_intDiv64Tick;
    end
  end

  // clock checkers; fallback uses the sticky fail bits
  logic [2:0] chkEnable;
  logic [2:0] chkFast;
  logic [2:0] chkSlow;

  assign chkEnable = {cfg.mainOscCheckEnable, cfg.intOscCheckEnable,
    cfg.pllCheckEnable};
  assign chkFast = {mainTick, intTick, pllTick};
  assign chkSlow = {intDiv64Tick, mainTick, mainTick};

  for (genvar i = 0; i < 3; i++)
  begin : g_chk
    pcg_clock_checker u_chk (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .enable(chkEnable[i]),
      .fastTick(chkFast[i]),
      .slowTick(chkSlow[i]),
      .clear(verifyClear),
      .fail(verifyFail[i])
    );
  end

  // relock timer and translation
  pcg_mode_type mode;
  pcg_mode_type next_mode;
  logic [3:0] prevCrystal;
  logic pllOnPrev;
  logic [`PCG_RELOCK_W-1:0] relockCount;
  logic [`PCG_RELOCK_W-1:0] next_relockCount;
  logic pllReady;
  logic next_pllReady;
  logic pllOn;
  logic relockTrigger;
  logic next_lockFlag;
  logic [31:0] xtalKhz;
  logic [31:0] multiplier;
  logic [15:0] next_translation;

  assign pllOn = !cfg.pllPowerDown && mode != PCG_DEEP;
  assign relockTrigger = cfg.crystalSelect != prevCrystal
    || (pllOn && !pllOnPrev);

  always_comb
  begin
    xtalKhz = `PCG_CRYSTAL_SELECT_BASE_KHZ
      + 32'(cfg.crystalSelect) * `PCG_CRYSTAL_SELECT_STEP_KHZ;
    // rounded, halved reference keeps the error near 0.5%
    multiplier = (`PCG_VCO_KHZ * `PCG_REF_DIV + (xtalKhz >> 1))
      / xtalKhz;
    next_translation = {2'h0, `PCG_REF_FIELD, multiplier[9:0]};
    next_relockCount = relockCount;
    if (relockTrigger)
      next_relockCount = `PCG_RELOCK_LOAD;
    else if (mainTick && relockCount != '0)
      next_relockCount = relockCount - 1'b1;
    next_pllReady = pllOn && !relockTrigger && next_relockCount == '0;
    next_lockFlag = pllLockRawFlag && !lockFlagClear;
    if (next_pllReady && !pllReady)
      next_lockFlag = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prevCrystal <= `PCG_CRYSTAL_SELECT_RESET;
      pllOnPrev <= 1'b0;
      relockCount <= '0;
      pllReady <= 1'b0;
      pllLockRawFlag <= 1'b0;
      lockIrq <= 1'b0;
      pllTranslation <= '0;
      pllPowerDown <= 1'b1;
      pllOutputDisable <= 1'b1;
    end
    else
    begin
      prevCrystal <= cfg.crystalSelect;
      pllOnPrev <= pllOn;
      relockCount <= next_relockCount;
      pllReady <= next_pllReady;
      pllLockRawFlag <= next_lockFlag;
      lockIrq <= next_lockFlag && cfg.lockIntMask;
      pllTranslation <= next_translation;
      pllPowerDown <= !pllOn;
      pllOutputDisable <= !pllOn || cfg.pllOutputDisable;
    end
  end

  // mode, clock source selection and gating
  pcg_src_type savedSel;
  pcg_src_type next_savedSel;
  pcg_src_type oscSel;
  pcg_src_type next_clkSel;
  logic [4:0] next_clkDivisor;
  logic [31:0] next_periph;
  logic [31:0] next_run;
  logic [31:0] next_sleep;
  logic [31:0] next_deep;

  always_comb
  begin
    unique case (cfg.oscSourceSelect)
      `PCG_OSC_INT: oscSel = PCG_SRC_INT;
      `PCG_OSC_INT4: oscSel = PCG_SRC_INT4;
      default: oscSel = PCG_SRC_MAIN;
    endcase
    next_mode = mode;
    next_savedSel = savedSel;
    next_clkDivisor = clkDivisor;
    next_clkSel = oscSel;
    unique case (mode)
      PCG_RUN:
      begin
        // pll only once relock is over; until then the oscillator
        if (!cfg.bypass && pllReady && !cfg.pllOutputDisable)
          next_clkSel = PCG_SRC_PLL;
        next_clkDivisor = cfg.useDivider
          ? 5'(cfg.systemDivider) + 5'h01 : 5'h01;
        if (sleepReq)
        begin
          next_mode = deepSleepEnable ? PCG_DEEP : PCG_SLEEP;
          next_savedSel = clkSel;
        end
      end
      PCG_SLEEP:
      begin
        next_clkSel = clkSel;
        if (wakeEvent)
          next_mode = PCG_RUN;
      end
      PCG_DEEP:
      begin
        next_clkSel = cfg.deepSleepIntOsc
          ? PCG_SRC_INT : PCG_SRC_MAIN;
        if (wakeEvent)
          next_mode = PCG_RESTORE;
      end
      PCG_RESTORE:
      begin
        // a saved pll source waits for relock after the power-up
        next_clkSel = (savedSel == PCG_SRC_PLL && !pllReady)
          ? oscSel : savedSel;
        if (clkSel == savedSel)
          next_mode = PCG_RUN;
      end
    endcase
    // fallback, held while the fail bits stay set
    if (next_clkSel == PCG_SRC_PLL && (verifyFail[`PCG_CHK_PLL]
      || verifyFail[`PCG_CHK_MAIN]))
      next_clkSel = PCG_SRC_MAIN;
    if ((next_clkSel == PCG_SRC_INT || next_clkSel == PCG_SRC_INT4)
      && verifyFail[`PCG_CHK_INT])
      next_clkSel = PCG_SRC_MAIN;
    if (next_clkSel == PCG_SRC_MAIN && verifyFail[`PCG_CHK_MAIN])
      next_clkSel = PCG_SRC_INT;
    next_run = gateWr.runWr ? gateWr.data & capabilityMask
      : runGating;
    next_sleep = gateWr.sleepWr ? gateWr.data & capabilityMask
      : sleepGating;
    next_deep = gateWr.deepWr ? gateWr.data & capabilityMask
      : deepGating;
    unique case (next_mode)
      PCG_SLEEP: next_periph = cfg.autoGating ? sleepGating
        : runGating;
      PCG_DEEP, PCG_RESTORE: next_periph = cfg.autoGating ? deepGating
        : runGating;
      default: next_periph = runGating;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode <= PCG_RUN;
      savedSel <= PCG_SRC_MAIN;
      clkSel <= PCG_SRC_MAIN;
      clkDivisor <= 5'h01;
      runGating <= `PCG_GATE0_RESET;
      sleepGating <= `PCG_GATE0_RESET;
      deepGating <= `PCG_GATE0_RESET;
      periphClkEnable <= '0;
      coreClkEnable <= 1'b1;
      mainOscPowerDown <= 1'b0;
      verifyIrq <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      savedSel <= next_savedSel;
      clkSel <= next_clkSel;
      clkDivisor <= next_clkDivisor;
      runGating <= next_run;
      sleepGating <= next_sleep;
      deepGating <= next_deep;
      periphClkEnable <= next_periph;
      coreClkEnable <= next_mode == PCG_RUN;
      mainOscPowerDown <= next_mode == PCG_DEEP
        && cfg.deepSleepIntOsc;
      verifyIrq <= |verifyFail;
    end
  end

  property p_pll_off;
    @(posedge sys_clk) disable iff (sys_rst)
    cfg.pllPowerDown |=> pllPowerDown && pllOutputDisable;
  endproperty
  a_pll_off: assert property (p_pll_off)
    else $error("pll not held down while power-down set");

  property p_no_relock;
    @(posedge sys_clk) disable iff (sys_rst)
    $stable(cfg.crystalSelect) && relockCount == '0 && pllOn && pllOnPrev
      |=> relockCount == '0;
  endproperty
  a_no_relock: assert property (p_no_relock)
    else $error("relock started without a trigger");

  property p_load;
    @(posedge sys_clk) disable iff (sys_rst)
    relockTrigger |=> relockCount == `PCG_RELOCK_LOAD && !pllReady;
  endproperty
  a_load: assert property (p_load)
    else $error("relock counter not loaded on trigger");

  property p_sel_ready;
    @(posedge sys_clk) disable iff (sys_rst)
    clkSel == PCG_SRC_PLL |-> $past(pllReady);
  endproperty
  a_sel_ready: assert property (p_sel_ready)
    else $error("pll selected before relock finished");

  property p_lock_flag;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(pllReady) |-> pllLockRawFlag;
  endproperty
  a_lock_flag: assert property (p_lock_flag)
    else $error("lock flag not raised with ready");

  property p_fallback;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(verifyFail[`PCG_CHK_PLL]) |-> ##1 clkSel != PCG_SRC_PLL
      && verifyIrq;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("pll failure did not switch clock or interrupt");

  property p_mask;
    @(posedge sys_clk) disable iff (sys_rst)
    gateWr.runWr |=> (runGating & ~$past(capabilityMask)) == '0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("gating bit set outside capability mask");

  property p_core_stop;
    @(posedge sys_clk) disable iff (sys_rst)
    mode != PCG_RUN |-> !coreClkEnable;
  endproperty
  a_core_stop: assert property (p_core_stop)
    else $error("core clock running outside run mode");

  property p_deep_pll;
    @(posedge sys_clk) disable iff (sys_rst)
    mode == PCG_DEEP ##1 mode == PCG_DEEP |-> pllPowerDown;
  endproperty
  a_deep_pll: assert property (p_deep_pll)
    else $error("pll left running in deep-sleep");

  property p_restore;
    @(posedge sys_clk) disable iff (sys_rst)
    mode == PCG_RESTORE ##1 mode == PCG_RUN |-> clkSel == savedSel;
  endproperty
  a_restore: assert property (p_restore)
    else $error("clocks re-enabled before source restored");

endmodule : pcg_clock_control

// [pcg_osc_model.sv]
// oscillator sources feeding the clock controller
`timescale 1ns/1ps
module pcg_osc_model (
  input wire logic mainRun,
  input wire logic intRun,
  input wire logic pllRun,
  output logic mainOsc,
  output logic intOsc,
  output logic pllTap
);
  // a stopped source freezes, as a dead crystal would
  initial
  begin
    mainOsc = 1'b0;
    intOsc = 1'b0;
    pllTap = 1'b0;
  end
  always #50 if (mainRun) mainOsc = ~mainOsc;
  always #30 if (intRun) intOsc = ~intOsc;
  always #35 if (pllRun) pllTap = ~pllTap;
endmodule : pcg_osc_model

// [tb.sv]
// self-checking bench of the clock controller
`timescale 1ns/1ps
module tb;
  import pcg_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [2:0] w;} pcg_grow_type;
  typedef struct {logic [1:0] s; logic [3:0] v; logic u; pcg_src_type e;
    logic [4:0] q;} pcg_srow_type;
  logic sys_clk, sys_rst, verifyClear, lockFlagClear, sleepReq;
  logic deepSleepEnable, wakeEvent, mainRun, intRun, pllRun;
  logic mainOscIn, intOscIn, pllTapIn, pllPowerDown, pllOutputDisable;
  logic pllLockRawFlag, lockIrq, verifyIrq, coreClkEnable, mainOscPowerDown;
  logic [31:0] capabilityMask, periphClkEnable, runGating, sleepGating;
  logic [31:0] deepGating, expRun, expSleep, expDeep;
  logic [15:0] pllTranslation;
  logic [4:0] clkDivisor;
  logic [2:0] verifyFail;
  pcg_src_type clkSel;
  pcg_cfg_type cfg;
  pcg_gate_wr_type gateWr;
  int errors, checks_done, cycles, n;
  pcg_grow_type grows [4] = '{'{32'hffff_ffff, 32'h0000_00ff, 3'b001},
    '{32'h1234_5678, 32'hffff_0000, 3'b010},
    '{32'hdead_beef, 32'h0f0f_0f0f, 3'b100},
    '{32'ha5a5_a5a5, 32'hffff_ffff, 3'b001}};
  pcg_srow_type srows [4] = '{'{2'h0, 4'h3, 1'b1, PCG_SRC_MAIN, 5'h04},
    '{2'h1, 4'hf, 1'b1, PCG_SRC_INT, 5'h10},
    '{2'h2, 4'h0, 1'b1, PCG_SRC_INT4, 5'h01},
    '{2'h3, 4'h7, 1'b0, PCG_SRC_MAIN, 5'h01}};

  pcg_osc_model u_pcg_osc_model (.mainRun(mainRun), .intRun(intRun),
    .pllRun(pllRun), .mainOsc(mainOscIn), .intOsc(intOscIn), .pllTap(pllTapIn));
  pcg_clock_control u_pcg_clock_control (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cfg(cfg), .gateWr(gateWr), .capabilityMask(capabilityMask),
    .verifyClear(verifyClear), .lockFlagClear(lockFlagClear),
    .sleepReq(sleepReq), .deepSleepEnable(deepSleepEnable),
    .wakeEvent(wakeEvent), .mainOscIn(mainOscIn), .intOscIn(intOscIn),
    .pllTapIn(pllTapIn), .pllTranslation(pllTranslation),
    .pllPowerDown(pllPowerDown), .pllOutputDisable(pllOutputDisable),
    .clkSel(clkSel), .clkDivisor(clkDivisor), .pllLockRawFlag(pllLockRawFlag),
    .lockIrq(lockIrq), .verifyFail(verifyFail), .verifyIrq(verifyIrq),
    .coreClkEnable(coreClkEnable), .periphClkEnable(periphClkEnable),
    .runGating(runGating), .sleepGating(sleepGating), .deepGating(deepGating),
    .mainOscPowerDown(mainOscPowerDown));

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc

  // vco error bound of one percent on the chosen crystal code
  task automatic chk_xlat(input logic [3:0] code);
    longint x;
    longint v;
    x = 4000 + 256 * code;
    v = x * pllTranslation[9:0] / 2;
    chk(32'(pllTranslation[15:10]), 32'h0000_0001);
    chk(32'(v >= 396000 && v <= 404000), 32'h0000_0001);
  endtask : chk_xlat

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 70000)
    begin
      errors++;
      finish_test();
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    {verifyClear, lockFlagClear, sleepReq, deepSleepEnable, wakeEvent} = '0;
    {mainRun, intRun, pllRun} = 3'b111;
    gateWr = '0;
    capabilityMask = '0;
    cfg = '0;
    cfg.pllPowerDown = 1'b1;
    cfg.pllOutputDisable = 1'b1;
    cfg.bypass = 1'b1;
    expRun = 32'h0000_0040;
    expSleep = 32'h0000_0040;
    expDeep = 32'h0000_0040;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    cyc(2);
    chk(32'(pllPowerDown), 32'h0000_0001);
    chk(32'(pllOutputDisable), 32'h0000_0001);
    chk(32'(clkSel), 32'(PCG_SRC_MAIN));
    chk(runGating, expRun);
    chk(periphClkEnable, expRun);
    chk_xlat(4'h0);
    foreach (grows[i])
    begin
      {gateWr.deepWr, gateWr.sleepWr, gateWr.runWr} = grows[i].w;
      gateWr.data = grows[i].d;
      capabilityMask = grows[i].m;
      if (grows[i].w[0]) expRun = grows[i].d & grows[i].m;
      if (grows[i].w[1]) expSleep = grows[i].d & grows[i].m;
      if (grows[i].w[2]) expDeep = grows[i].d & grows[i].m;
      cyc(1);
      gateWr = '0;
      cyc(1);
      chk(runGating, expRun);
      chk(sleepGating, expSleep);
      chk(deepGating, expDeep);
      chk(periphClkEnable, expRun);
    end
    foreach (srows[i])
    begin
      cfg.oscSourceSelect = srows[i].s;
      cfg.systemDivider = srows[i].v;
      cfg.useDivider = srows[i].u;
      cyc(2);
      chk(32'(clkSel), 32'(srows[i].e));
      chk(32'(clkDivisor), 32'(srows[i].q));
    end
    cfg.autoGating = 1'b1;
    sleepReq = 1'b1;
    cyc(1);
    sleepReq = 1'b0;
    cyc(1);
    chk(32'(coreClkEnable), 32'h0000_0000);
    chk(periphClkEnable, expSleep);
    chk(32'(clkSel), 32'(PCG_SRC_MAIN));
    wakeEvent = 1'b1;
    cyc(1);
    wakeEvent = 1'b0;
    cyc(1);
    chk(32'(coreClkEnable), 32'h0000_0001);
    // enable and select the pll in one step
    {cfg.bypass, cfg.pllPowerDown, cfg.pllOutputDisable} = 3'b000;
    cfg.lockIntMask = 1'b1;
    cyc(100);
    chk(32'(pllPowerDown), 32'h0000_0000);
    chk(32'(pllOutputDisable), 32'h0000_0000);
    chk(32'(clkSel), 32'(PCG_SRC_MAIN));
    chk(32'(pllLockRawFlag), 32'h0000_0000);
    n = 100;
    while (pllLockRawFlag !== 1'b1 && n < 20000)
    begin
      cyc(1);
      n++;
    end
    // 0x1200 ticks at four clock cycles per main tick
    chk(32'(n >= 18400 && n <= 18500), 32'h0000_0001);
    chk(32'(lockIrq), 32'h0000_0001);
    cyc(2);
    chk(32'(clkSel), 32'(PCG_SRC_PLL));
    cfg.pllCheckEnable = 1'b1;
    cfg.intOscCheckEnable = 1'b1;
    cyc(50);
    chk(32'(verifyFail), 32'h0000_0000);
    pllRun = 1'b0;
    cyc(20);
    chk(32'(verifyFail), 32'h0000_0001);
    chk(32'(verifyIrq), 32'h0000_0001);
    chk(32'(clkSel), 32'(PCG_SRC_MAIN));
    pllRun = 1'b1;
    cyc(20);
    chk(32'(verifyFail), 32'h0000_0001);
    verifyClear = 1'b1;
    cyc(1);
    verifyClear = 1'b0;
    cyc(3);
    chk(32'(verifyFail), 32'h0000_0000);
    chk(32'(clkSel), 32'(PCG_SRC_PLL));
    cfg.deepSleepIntOsc = 1'b1;
    deepSleepEnable = 1'b1;
    sleepReq = 1'b1;
    cyc(1);
    sleepReq = 1'b0;
    cyc(1);
    chk(32'(coreClkEnable), 32'h0000_0000);
    chk(periphClkEnable, expDeep);
    chk(32'(pllPowerDown), 32'h0000_0001);
    chk(32'(clkSel), 32'(PCG_SRC_INT));
    chk(32'(mainOscPowerDown), 32'h0000_0001);
    wakeEvent = 1'b1;
    cyc(1);
    wakeEvent = 1'b0;
    deepSleepEnable = 1'b0;
    cyc(3);
    chk(32'(coreClkEnable), 32'h0000_0000);
    n = 0;
    while (coreClkEnable !== 1'b1 && n < 20000)
    begin
      cyc(1);
      n++;
    end
    chk(32'(clkSel), 32'(PCG_SRC_PLL));
    chk(32'(n > 18000), 32'h0000_0001);
    lockFlagClear = 1'b1;
    cyc(1);
    lockFlagClear = 1'b0;
    cyc(50);
    chk(32'(pllLockRawFlag), 32'h0000_0000);
    chk(32'(clkSel), 32'(PCG_SRC_PLL));
    cfg.crystalSelect = 4'h8;
    cyc(3);
    chk(32'(clkSel), 32'(PCG_SRC_MAIN));
    chk_xlat(4'h8);
    cyc(1000);
    // reprogram bypassed, release bypass only after lock
    cfg.bypass = 1'b1;
    cfg.useDivider = 1'b0;
    cyc(1);
    cfg.crystalSelect = 4'h9;
    n = 0;
    cyc(1);
    cfg.useDivider = 1'b1;
    while (pllLockRawFlag !== 1'b1 && n < 20000)
    begin
      cyc(1);
      n++;
    end
    // second trigger mid-count restarts the full count
    chk(32'(n >= 18400 && n <= 18500), 32'h0000_0001);
    chk(32'(clkSel), 32'(PCG_SRC_MAIN));
    chk(32'(clkDivisor), 32'h0000_0008);
    cfg.bypass = 1'b0;
    cyc(2);
    chk(32'(clkSel), 32'(PCG_SRC_PLL));
    cfg.mainOscCheckEnable = 1'b1;
    cyc(400);
    chk(32'(verifyFail[2]), 32'h0000_0000);
    mainRun = 1'b0;
    cyc(600);
    chk(32'(verifyFail[2]), 32'h0000_0001);
    chk(32'(clkSel), 32'(PCG_SRC_INT));
    finish_test();
  end
endmodule : tb
